// ==== hw/fma_fault_monitor.sv ====
// Fault monitor aggregator: sticky diagnostic flags, fault line and monitor converter control
// Overview of operation
// - Both die temperature comparators are always live; nothing can disable them.
// - Four trip points chosen in general config one drive both die sensors.
// - A die over its limit sets its temperature flag and pulls the fault line unless masked.
// - Supply window comparators reset off; enabled only by general config two bits.
// - Four window flags set whenever their enabled comparator reports out of window.
// - Analog flags are sticky; writing one reloads them with the present condition.
// - Fault line is active low open drain and floats with no enabled fault.
// - Every readback carries a bit that is the inverse of the fault line level.
// - Interface, background CRC and memory CRC errors always drive fault; clock count error unless quiet.
// - Ten digital faults drive the fault line unless masked in fault config.
// - Memory unrefreshed, reset detected and capacitor detect never drive fault.
// - Six analog faults drive the fault line unless masked.
// - Converter power and four window errors always drive fault, no mask.
// - Status offers digital, analog and watchdog summary bits.
// - Monitor converter gives 12-bit results, single or sequence mode by config.
// - Summary bits are live ORs of flags, digital one excluding slew busy.
// - Quiet enable bit removes the clock count error from the fault line.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
module fma_fault_monitor (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [fma_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [fma_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [fma_pkg::RD_W-1:0] reg_rdata_out,
  // Analog comparators and fault line level
  input wire logic [1:0] temp_over_in,
  input wire logic [fma_pkg::CMP_W-1:0] window_fault_in,
  input wire logic [5:0] analog_fault_in,
  input wire logic fault_line_in,
  // Digital diagnostics on this clock
  input wire logic [fma_pkg::DIG_W-1:0] digital_event_in,
  input wire logic slew_busy_in,
  // Analog configuration
  output logic [fma_pkg::TRIP_W-1:0] trip_select_out,
  output logic [fma_pkg::CMP_W-1:0] comparator_enable_out,
  output logic reference_buffer_enable_out,
  // Monitor converter
  output logic [fma_pkg::SEL_W-1:0] monitor_input_select_out,
  output logic adc_start_out,
  input wire logic adc_done_in,
  input wire logic [fma_pkg::ADC_W-1:0] adc_data_in,
  // Fault pin
  output logic fault_pin_out,
  output logic fault_pin_oe_out
);
  import fma_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] cfg_one;
    logic [DATA_W-1:0] cfg_two;
    logic [DATA_W-1:0] conv_cfg;
    logic [DATA_W-1:0] fault_mask;
    logic [DATA_W-1:0] ana_mask;
    logic [DATA_W-1:0] adc_cfg;
    logic [DIG_W-1:0] dig_flags;
    logic [ANA_W-1:0] ana_flags;
    logic [ADC_W-1:0] adc_result;
    fma_adc_t adc_state;
    logic adc_start;
    logic [RD_W-1:0] rdata;
  } fma_state_t;

  fma_state_t s;
  fma_state_t next_s;
  logic [ASYNC_W-1:0] sync;
  logic [ANA_W-1:0] ana_cond;
  logic [CMP_W-1:0] cmp_en;
  logic [DIG_W-1:0] dig_w1;
  logic [ANA_W-1:0] ana_w1;
  logic [DIG_W-1:0] dig_map;
  logic [ANA_W-1:0] ana_map;
  logic fault_active;
  logic line_status;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] rd_mux;
  logic wr_adc;

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  fma_sync3 #(
    .W(ASYNC_W),
    .RST_VAL(SYNC_RST)
  ) u_sync (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .async_in({fault_line_in, analog_fault_in, window_fault_in, temp_over_in}),
    .sync_out(sync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Flag conditions and fault line
  always_comb begin
    cmp_en = s.cfg_two[CFG2_CMP_LSB +: CMP_W];
    ana_cond = '0;
    ana_cond[AN_OVV] = sync[AS_OVV];
    ana_cond[AN_CONV_SHORT] = sync[AS_CONV_SHORT];
    ana_cond[AN_CONV_POWER] = sync[AS_CONV_POWER];
    ana_cond[AN_CAP_DET] = sync[AS_CAP];
    ana_cond[AN_OPEN] = sync[AS_OPEN];
    ana_cond[AN_VSHORT] = sync[AS_VSHORT];
    // Temperature comparators are never gated
    ana_cond[AN_CONV_TEMP] = sync[AS_TEMP_LSB];
    ana_cond[AN_MAIN_TEMP] = sync[AS_TEMP_LSB + 1];
    // Each window flag follows its own comparator, gated by its enable bit
    ana_cond[AN_WIN_LSB +: CMP_W] = sync[AS_WIN_LSB +: CMP_W] & cmp_en;
    dig_map = (DIG_MASKABLE & ~s.fault_mask[DIG_W-1:0]) | DIG_ALWAYS;
    dig_map[DG_SCLK] = ~s.cfg_one[CFG1_QUIET_BIT];
    ana_map = (ANA_MASKABLE & ~s.ana_mask[ANA_W-1:0]) | ANA_ALWAYS;
    fault_active = |(s.dig_flags & dig_map) | |(s.ana_flags & ana_map);
    line_status = ~sync[AS_PIN];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register reads
  always_comb begin
    status_word = '0;
    status_word[ST_ADC_LSB +: ADC_W] = s.adc_result;
    status_word[ST_DIG_BIT] = |s.dig_flags;
    status_word[ST_ANA_BIT] = |s.ana_flags;
    status_word[ST_WDT_BIT] = s.dig_flags[DG_WDT_LATE] | s.dig_flags[DG_WDT_EARLY];
    status_word[ST_SLEW_BIT] = slew_busy_in;
    unique case (reg_addr_in)
      ADDR_CONV_CFG: rd_mux = s.conv_cfg;
      ADDR_CFG_ONE: rd_mux = s.cfg_one;
      ADDR_CFG_TWO: rd_mux = s.cfg_two;
      ADDR_ADC_CFG: rd_mux = s.adc_cfg;
      ADDR_FAULT_CFG: rd_mux = s.fault_mask;
      ADDR_ANA_MASK: rd_mux = s.ana_mask;
      ADDR_DIG_RES: rd_mux = s.dig_flags;
      ADDR_ANA_RES: rd_mux = {{(DATA_W-ANA_W){1'b0}}, s.ana_flags};
      ADDR_STATUS: rd_mux = status_word;
      default: rd_mux = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_s = s;
    dig_w1 = '0;
    ana_w1 = '0;
    wr_adc = reg_wr_in && (reg_addr_in == ADDR_ADC_CFG);
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        ADDR_CONV_CFG: next_s.conv_cfg = reg_wdata_in;
        ADDR_CFG_ONE: next_s.cfg_one = reg_wdata_in;
        ADDR_CFG_TWO: next_s.cfg_two = reg_wdata_in;
        ADDR_ADC_CFG: begin
          next_s.adc_cfg = reg_wdata_in;
          next_s.adc_cfg[ADC_START_BIT] = 1'b0;
        end
        ADDR_FAULT_CFG: next_s.fault_mask = reg_wdata_in;
        ADDR_ANA_MASK: next_s.ana_mask = reg_wdata_in;
        ADDR_DIG_RES: dig_w1 = reg_wdata_in;
        ADDR_ANA_RES: ana_w1 = reg_wdata_in[ANA_W-1:0];
        default: next_s.rdata = s.rdata;
      endcase
    end
    // A written one reloads a flag with the live condition; a new event always wins
    next_s.dig_flags = (s.dig_flags & ~dig_w1) | digital_event_in;
    next_s.ana_flags = (s.ana_flags & ~ana_w1) | ana_cond;
    next_s.rdata = '0;
    if (reg_rd_in) begin
      next_s.rdata = {line_status, rd_mux};
    end
    // Monitor converter: single start on request, sequence mode restarts itself
    next_s.adc_start = 1'b0;
    unique case (s.adc_state)
      FMA_ADC_IDLE: begin
        if (wr_adc && reg_wdata_in[ADC_START_BIT]) begin
          next_s.adc_state = FMA_ADC_BUSY;
          next_s.adc_start = 1'b1;
        end
      end
      FMA_ADC_BUSY: begin
        if (adc_done_in) begin
          next_s.adc_result = adc_data_in;
          if (s.adc_cfg[ADC_SEQ_BIT]) begin
            next_s.adc_start = 1'b1;
          end else begin
            next_s.adc_state = FMA_ADC_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      s.cfg_one <= CFG1_RST;
      s.cfg_two <= REG_RST;
      s.conv_cfg <= REG_RST;
      s.fault_mask <= REG_RST;
      s.ana_mask <= REG_RST;
      s.adc_cfg <= REG_RST;
      s.dig_flags <= DIG_FLAGS_RST;
      s.ana_flags <= '0;
      s.adc_result <= '0;
      s.adc_state <= FMA_ADC_IDLE;
      s.adc_start <= 1'b0;
      s.rdata <= '0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata_out = s.rdata;
  assign trip_select_out = s.cfg_one[CFG1_TRIP_LSB +: TRIP_W];
  assign comparator_enable_out = cmp_en;
  assign reference_buffer_enable_out = s.conv_cfg[CONV_INT_EN_BIT];
  assign monitor_input_select_out = s.adc_cfg[ADC_SEL_LSB +: SEL_W];
  assign adc_start_out = s.adc_start;
  // Open drain: drive low only while a fault is present
  assign fault_pin_out = 1'b0;
  assign fault_pin_oe_out = fault_active;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence seq_seq_done;
    s.adc_state == FMA_ADC_BUSY && adc_done_in && s.adc_cfg[ADC_SEQ_BIT];
  endsequence
  sequence seq_restart;
    adc_start_out && s.adc_state == FMA_ADC_BUSY;
  endsequence

  chk_temp_flag_set: assert property (sync[AS_TEMP_LSB + 1] |=> s.ana_flags[AN_MAIN_TEMP] && fault_pin_oe_out || s.ana_mask[AN_MAIN_TEMP]) else $error("main die temperature flag not set");
  chk_trip_write: assert property (reg_wr_in && reg_addr_in == ADDR_CFG_ONE |=> trip_select_out == $past(reg_wdata_in[TRIP_W-1:0])) else $error("trip select not updated");
  chk_window_gate: assert property (!cmp_en[0] && !s.ana_flags[AN_WIN_LSB] |=> !s.ana_flags[AN_WIN_LSB]) else $error("disabled window flag set");
  chk_window_set: assert property (cmp_en[1] && sync[AS_WIN_LSB + 1] |=> s.ana_flags[AN_WIN_LSB + 1]) else $error("enabled window flag missed");
  chk_sticky_hold: assert property (s.ana_flags[AN_OPEN] && !(reg_wr_in && reg_addr_in == ADDR_ANA_RES) |=> s.ana_flags[AN_OPEN]) else $error("sticky flag dropped");
  chk_w1_reload: assert property (reg_wr_in && reg_addr_in == ADDR_ANA_RES && reg_wdata_in[AN_OPEN] && !sync[AS_OPEN] |=> !s.ana_flags[AN_OPEN]) else $error("flag not reloaded");
  chk_always_fault: assert property (s.ana_flags[AN_CONV_POWER] || s.dig_flags[DG_THREE_WIRE] |-> fault_pin_oe_out && !fault_pin_out) else $error("unmaskable fault not driven");
  chk_mask_blocks: assert property (s.dig_flags == (16'h0001 << DG_LATCH) && s.ana_flags == '0 && s.fault_mask[DG_LATCH] |-> !fault_pin_oe_out) else $error("masked fault drives line");
  chk_never_mapped: assert property ((s.dig_flags & ~DIG_FLAGS_RST & 16'hfffd) == '0 && (s.ana_flags & ~(12'h001 << AN_CAP_DET)) == '0 |-> !fault_pin_oe_out) else $error("unmapped flag drives line");
  chk_quiet_sclk: assert property (s.cfg_one[CFG1_QUIET_BIT] && s.dig_flags == (16'h0001 << DG_SCLK) && s.ana_flags == '0 |-> !fault_pin_oe_out) else $error("quiet clock count error drives line");
  chk_line_status: assert property (reg_rd_in |=> reg_rdata_out[RD_FLT_BIT] == !$past(sync[AS_PIN])) else $error("fault line status wrong");
  chk_summary_read: assert property (reg_rd_in && reg_addr_in == ADDR_STATUS |=> reg_rdata_out[ST_ANA_BIT] == |$past(s.ana_flags) && reg_rdata_out[ST_DIG_BIT] == |$past(s.dig_flags)) else $error("summary bit wrong");
  chk_seq_restart: assert property (seq_seq_done |=> seq_restart ##1 !adc_start_out) else $error("sequence mode did not restart");
  chk_adc_result: assert property (s.adc_state == FMA_ADC_BUSY && adc_done_in |=> s.adc_result == $past(adc_data_in)) else $error("conversion result not stored");
endmodule // fma_fault_monitor

// ==== hw/fma_pkg.sv ====
// Shared constants and types of the fault monitor aggregator
package fma_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int RD_W = 17;
  localparam int DIG_W = 16;
  localparam int ANA_W = 12;
  localparam int ADC_W = 12;
  localparam int SEL_W = 5;
  localparam int CMP_W = 4;
  localparam int TRIP_W = 2;
  localparam int ASYNC_W = 13;

  ////////////////////////////////////////////////////////////////////////////////
  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_CONV_CFG = 5'h06;
  localparam logic [ADDR_W-1:0] ADDR_CFG_ONE = 5'h09;
  localparam logic [ADDR_W-1:0] ADDR_CFG_TWO = 5'h0a;
  localparam logic [ADDR_W-1:0] ADDR_ADC_CFG = 5'h11;
  localparam logic [ADDR_W-1:0] ADDR_FAULT_CFG = 5'h12;
  localparam logic [ADDR_W-1:0] ADDR_ANA_MASK = 5'h13;
  localparam logic [ADDR_W-1:0] ADDR_DIG_RES = 5'h14;
  localparam logic [ADDR_W-1:0] ADDR_ANA_RES = 5'h15;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h16;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CFG1_TRIP_LSB = 0;
  localparam int CFG1_QUIET_BIT = 3;
  localparam int CFG2_CMP_LSB = 0;
  localparam int CONV_INT_EN_BIT = 0;
  localparam int ADC_SEL_LSB = 0;
  localparam int ADC_SEQ_BIT = 8;
  localparam int ADC_START_BIT = 9;
  localparam int ST_ADC_LSB = 0;
  localparam int ST_DIG_BIT = 12;
  localparam int ST_ANA_BIT = 13;
  localparam int ST_WDT_BIT = 14;
  localparam int ST_SLEW_BIT = 15;
  localparam int RD_FLT_BIT = 16;

  // Digital flag positions
  localparam int DG_OSC = 0;
  localparam int DG_CAL_UNREF = 1;
  localparam int DG_RESET = 2;
  localparam int DG_THREE_WIRE = 3;
  localparam int DG_WDT_LATE = 4;
  localparam int DG_WDT_EARLY = 5;
  localparam int DG_BG_CRC = 6;
  localparam int DG_LATCH = 7;
  localparam int DG_DUAL = 8;
  localparam int DG_INVERSE = 9;
  localparam int DG_CAL_CRC = 10;
  localparam int DG_INV_ACCESS = 11;
  localparam int DG_LOCKED_WR = 12;
  localparam int DG_SCLK = 13;
  localparam int DG_SLIP = 14;
  localparam int DG_SER_CRC = 15;

  // Analog flag positions
  localparam int AN_OVV = 0;
  localparam int AN_CONV_SHORT = 1;
  localparam int AN_CONV_POWER = 2;
  localparam int AN_CAP_DET = 3;
  localparam int AN_OPEN = 4;
  localparam int AN_VSHORT = 5;
  localparam int AN_CONV_TEMP = 6;
  localparam int AN_MAIN_TEMP = 7;
  localparam int AN_WIN_LSB = 8;

  // Synchronised input positions
  localparam int AS_TEMP_LSB = 0;
  localparam int AS_WIN_LSB = 2;
  localparam int AS_OVV = 6;
  localparam int AS_CONV_SHORT = 7;
  localparam int AS_CONV_POWER = 8;
  localparam int AS_OPEN = 9;
  localparam int AS_VSHORT = 10;
  localparam int AS_CAP = 11;
  localparam int AS_PIN = 12;

  ////////////////////////////////////////////////////////////////////////////////
  // Fault line mapping
  localparam logic [DIG_W-1:0] DIG_MASKABLE = 16'hdbb1;
  localparam logic [DIG_W-1:0] DIG_ALWAYS = 16'h2448;
  localparam logic [ANA_W-1:0] ANA_MASKABLE = 12'h0f3;
  localparam logic [ANA_W-1:0] ANA_ALWAYS = 12'hf04;

  // Reset values
  localparam logic [DATA_W-1:0] CFG1_RST = 16'h0003;
  localparam logic [DATA_W-1:0] REG_RST = 16'h0000;
  localparam logic [DIG_W-1:0] DIG_FLAGS_RST = 16'h0004;
  localparam logic [ASYNC_W-1:0] SYNC_RST = 13'h1000;

  typedef enum logic [TRIP_W-1:0] {FMA_TRIP_97C, FMA_TRIP_112C, FMA_TRIP_127C, FMA_TRIP_142C} fma_trip_t;
  typedef enum logic {FMA_ADC_IDLE, FMA_ADC_BUSY} fma_adc_t;
endpackage

// ==== hw/fma_sync3.sv ====
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module fma_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } fma_sync_t;

  fma_sync_t s;
  fma_sync_t next_s;
  logic [W-1:0] agree;

  always_comb begin
    agree = ~(s.s2 ^ s.s3);
    next_s.s1 = async_in;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.q = (s.s3 & agree) | (s.q & ~agree);
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.q;
endmodule // fma_sync3

// ==== sim/fma_fault_monitor_bench.sv ====
// Self-checking bench of the fault monitor aggregator
`timescale 1ns/10ps
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
  $display("CHECK FAILED t=%0t %s", $time, msg); end end
module fma_fault_monitor_bench;
  import fma_pkg::*;
  logic mclk_in, rst_in, reg_wr, reg_rd, slew_busy, adc_start, adc_done, fault_pin, fault_oe;
  logic fault_line, rbuf_en;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [RD_W-1:0] rdata, rv;
  logic [1:0] temp_over;
  logic [CMP_W-1:0] win_fault, cmp_en;
  logic [5:0] ana_fault;
  logic [DIG_W-1:0] dig_event;
  logic [TRIP_W-1:0] trip_sel;
  logic [SEL_W-1:0] mon_sel;
  logic [ADC_W-1:0] adc_data;
  int failures, cmp_count;

  fma_fault_monitor uut (.mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
    .temp_over_in(temp_over), .window_fault_in(win_fault), .analog_fault_in(ana_fault),
    .fault_line_in(fault_line), .digital_event_in(dig_event), .slew_busy_in(slew_busy),
    .trip_select_out(trip_sel), .comparator_enable_out(cmp_en),
    .reference_buffer_enable_out(rbuf_en), .monitor_input_select_out(mon_sel),
    .adc_start_out(adc_start), .adc_done_in(adc_done), .adc_data_in(adc_data),
    .fault_pin_out(fault_pin), .fault_pin_oe_out(fault_oe));
  fma_host_model #(.CONV_CYCLES(5)) host (.mclk_in(mclk_in), .rst_in(rst_in),
    .fault_pin_in(fault_pin), .fault_pin_oe_in(fault_oe), .fault_line_out(fault_line),
    .adc_start_in(adc_start), .adc_done_out(adc_done), .adc_data_out(adc_data));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  initial begin
    repeat (100000) @(posedge mclk_in);
    failures++;
    $display("CHECK FAILED t=%0t run timed out", $time);
    results;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk_in);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk_in);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [RD_W-1:0] d);
    @(posedge mclk_in);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk_in);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Long enough for the synchroniser and the registered flags
  task automatic settle;
    repeat (6) @(posedge mclk_in);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    `CHK(trip_sel, 2'h3, "trip after reset")
    `CHK({cmp_en, rbuf_en, fault_oe}, 6'h00, "config after reset")
    rd_reg(ADDR_CFG_ONE, rv);
    `CHK(rv[15:0], 16'h0003, "config one reset value")
    rd_reg(ADDR_DIG_RES, rv);
    `CHK(rv[15:0], 16'h0004, "reset detected flag")
    rd_reg(ADDR_STATUS, rv);
    `CHK({rv[16], rv[12]}, 2'b01, "status after reset")
    rd_reg(5'h1f, rv);
    `CHK(rv[15:0], 16'h0000, "unmapped read")
    wr_reg(ADDR_DIG_RES, 16'hffff);
    rd_reg(ADDR_DIG_RES, rv);
    `CHK(rv[15:0], 16'h0000, "reset flag reload")
    wr_reg(ADDR_CONV_CFG, 16'h0001);
    #1 `CHK(rbuf_en, 1'b1, "buffer enable")
    wr_reg(ADDR_CONV_CFG, 16'h0000);
    $display("test reset done");
  endtask

  task automatic test_temp;
    for (int t = 0; t < 4; t++) begin
      wr_reg(ADDR_CFG_ONE, 16'(t));
      #1 `CHK(trip_sel, 2'(t), "trip code")
    end
    temp_over <= 2'b11;
    settle;
    `CHK(fault_oe, 1'b1, "temperature fault line")
    wr_reg(ADDR_ANA_RES, 16'h00c0);
    rd_reg(ADDR_ANA_RES, rv);
    `CHK(rv[11:0], 12'h0c0, "temperature flags sticky")
    wr_reg(ADDR_ANA_MASK, 16'h00c0);
    #1 `CHK(fault_oe, 1'b0, "temperature masked")
    wr_reg(ADDR_ANA_MASK, 16'h0000);
    temp_over <= 2'b00;
    settle;
    wr_reg(ADDR_ANA_RES, 16'h00c0);
    rd_reg(ADDR_ANA_RES, rv);
    `CHK({rv[11:0], fault_oe}, 13'h0000, "temperature cleared")
    $display("test temperature done");
  endtask

  task automatic test_window;
    win_fault <= 4'hf;
    settle;
    rd_reg(ADDR_ANA_RES, rv);
    `CHK({rv[11:0], fault_oe}, 13'h0000, "windows off by default")
    wr_reg(ADDR_CFG_TWO, 16'h000f);
    wr_reg(ADDR_ANA_MASK, 16'h0fff);
    `CHK(cmp_en, 4'hf, "comparator enables")
    settle;
    rd_reg(ADDR_ANA_RES, rv);
    `CHK({rv[11:8], fault_oe}, 5'h1f, "window flags unmaskable")
    rd_reg(ADDR_STATUS, rv);
    `CHK({rv[16], rv[13]}, 2'b11, "analog summary and line status")
    win_fault <= 4'h0;
    settle;
    wr_reg(ADDR_ANA_RES, 16'h0fff);
    wr_reg(ADDR_CFG_TWO, 16'h0000);
    #1 `CHK(fault_oe, 1'b0, "window cleared")
    $display("test window done");
  endtask

  task automatic test_analog;
    int af[6] = '{0, 1, 2, 4, 5, 3};
    logic [ANA_W-1:0] m;
    for (int k = 0; k < 2; k++) begin
      m = k ? 12'hfff : 12'h000;
      wr_reg(ADDR_ANA_MASK, 16'(m));
      for (int i = 0; i < 6; i++) begin
        ana_fault <= 6'h1 << i;
        settle;
        ana_fault <= 6'h0;
        settle;
        `CHK(fault_oe, (i == 2) | (i != 5 && !m[af[i]]), "analog mapping")
        rd_reg(ADDR_ANA_RES, rv);
        `CHK(rv[11:0], 12'h1 << af[i], "analog flag sticky")
        wr_reg(ADDR_ANA_RES, 16'h0fff);
      end
    end
    wr_reg(ADDR_ANA_MASK, 16'h0000);
    $display("test analog done");
  endtask

  task automatic test_digital;
    logic [DIG_W-1:0] alw, nev, m;
    alw = (16'h1 << DG_THREE_WIRE) | (16'h1 << DG_BG_CRC) | (16'h1 << DG_CAL_CRC)
        | (16'h1 << DG_SCLK);
    nev = (16'h1 << DG_CAL_UNREF) | (16'h1 << DG_RESET);
    for (int k = 0; k < 3; k++) begin
      m = (k == 1) ? 16'hffff : 16'h0000;
      wr_reg(ADDR_FAULT_CFG, m);
      wr_reg(ADDR_CFG_ONE, (k == 2) ? 16'h0008 : 16'h0003);
      for (int i = 0; i < DIG_W; i++) begin
        @(posedge mclk_in);
        dig_event <= 16'h1 << i;
        @(posedge mclk_in);
        dig_event <= 16'h0;
        @(posedge mclk_in);
        #1 `CHK(fault_oe, (alw[i] | (!nev[i] & !m[i])) & !(k == 2 && i == DG_SCLK), "dig map")
        settle;
        rd_reg(ADDR_STATUS, rv);
        `CHK({rv[16], rv[14], rv[12]}, {fault_oe, i == 4 || i == 5, 1'b1}, "dig status")
        wr_reg(ADDR_DIG_RES, 16'h1 << i);
        #1 `CHK(fault_oe, 1'b0, "digital flag cleared")
      end
    end
    slew_busy <= 1'b1;
    rd_reg(ADDR_STATUS, rv);
    `CHK({rv[15], rv[12]}, 2'b10, "slew busy not summarised")
    slew_busy <= 1'b0;
    wr_reg(ADDR_FAULT_CFG, 16'h0000);
    $display("test digital done");
  endtask

  task automatic test_adc;
    int n;
    wr_reg(ADDR_ADC_CFG, 16'h021f);
    #1 `CHK({adc_start, mon_sel}, 6'h3f, "single start and select")
    n = 0;
    while (adc_done !== 1'b1 && n < 50) begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    `CHK(n < 50, 1'b1, "converter finished")
    rd_reg(ADDR_STATUS, rv);
    `CHK(rv[11:0], 12'ha5c, "conversion result")
    wr_reg(ADDR_ADC_CFG, 16'h031f);
    n = 0;
    repeat (40) begin
      @(posedge mclk_in);
      #1 n += int'(adc_start === 1'b1);
    end
    `CHK(n >= 3, 1'b1, "sequence restarts")
    wr_reg(ADDR_ADC_CFG, 16'h0000);
    repeat (20) @(posedge mclk_in);
    $display("test converter done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    cmp_count = 0;
    rst_in = 1'b1;
    {reg_wr, reg_rd, slew_busy} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    temp_over = '0;
    win_fault = '0;
    ana_fault = '0;
    dig_event = '0;
    repeat (16) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    #1;
    test_reset;
    test_temp;
    test_window;
    test_analog;
    test_digital;
    test_adc;
    results;
  end
endmodule // fma_fault_monitor_bench

// ==== sim/fma_host_model.sv ====
// Far-side model: pulled-up shared fault wire and monitor converter responder
`timescale 1ns/10ps
module fma_host_model #(
  parameter int CONV_CYCLES = 5
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Fault pin of the device
  input wire logic fault_pin_in,
  input wire logic fault_pin_oe_in,
  output logic fault_line_out,
  // Monitor converter
  input wire logic adc_start_in,
  output logic adc_done_out,
  output logic [fma_pkg::ADC_W-1:0] adc_data_out
);
  import fma_pkg::*;
  int cnt;
  logic busy;
  logic [ADC_W-1:0] code;
  // Pull-up holds the wire high unless the device sinks it
  assign fault_line_out = (fault_pin_oe_in && !fault_pin_in) ? 1'b0 : 1'b1;
  // Result is only valid with done; otherwise show the inverse
  assign adc_data_out = adc_done_out ? code : ~code;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= 0;
      busy <= 1'b0;
      adc_done_out <= 1'b0;
      code <= 12'ha5c;
    end else begin
      adc_done_out <= 1'b0;
      if (adc_done_out) begin
        code <= code + 12'h111;
      end
      if (adc_start_in) begin
        busy <= 1'b1;
        cnt <= 0;
      end else if (busy) begin
        cnt <= cnt + 1;
        if (cnt == CONV_CYCLES) begin
          busy <= 1'b0;
          adc_done_out <= 1'b1;
        end
      end
    end
  end
endmodule // fma_host_model
